// [core/fabric_map.vh]
// Constants for the routing fabric and pin cells: sizes, selector codes and reset values.
`ifndef FABRIC_MAP_VH
`define FABRIC_MAP_VH

// Array dimensions of the smaller variants; the largest uses 186 row and 30 column channels.
`define ROW_CH_DEF 144
`define COL_CH_DEF 20
`define NCOL_DEF 22
`define NPIN_DEF 20
`define NLOCAL_DEF 24

// Fixed structure of one logic cluster, the global network, the row channel groups and the selector fields.
`define CELLS 10
`define HALF_CELLS 5
`define GLOBALS 4
`define GROUP_SIZE 6
`define SEL_W 8

// Row group driver selector codes (three sources plus off).
`define GSEL_OFF 2'h0
`define GSEL_CELL 2'h1
`define GSEL_COLA 2'h2
`define GSEL_COLB 2'h3

// Column channel driver selector codes.
`define CSEL_PASS 2'h0
`define CSEL_GLOBAL 2'h1
`define CSEL_LOCAL 2'h2
`define CSEL_PIN 2'h3

// Pin cell modes.
`define PMODE_INPUT 2'h0
`define PMODE_OUTPUT 2'h1
`define PMODE_BIDIR 2'h2
`define PMODE_UNUSED 2'h3

// Reset value of every configuration field.
`define CFG_RESET 1'h0

`endif

// [core/routing_fabric.v]
// One row of the configurable routing fabric with its clusters, global nets and pin cells.
`default_nettype none

`include "fabric_map.vh"

module routing_fabric #(
	parameter ROW_CH = `ROW_CH_DEF,
	parameter COL_CH = `COL_CH_DEF,
	parameter NCOL = `NCOL_DEF,
	parameter NPIN = `NPIN_DEF,
	parameter NLOCAL = `NLOCAL_DEF
) (
	// Clock and synchronous reset.
	input wire REF_CLK,
	input wire RESETN,
	// Configuration load strobe and configuration fields.
	input wire CFG_LOAD,
	input wire [2*((ROW_CH+ROW_CH/3+5)/6)-1:0] GRP_SEL,
	input wire [NCOL*NLOCAL*`SEL_W-1:0] LOC_SEL,
	input wire [NCOL*6-1:0] CTRL_SEL,
	input wire [NCOL*COL_CH*2-1:0] COL_SEL,
	input wire [`GLOBALS-1:0] GLB_SRC,
	input wire [`GLOBALS*`SEL_W-1:0] GLB_TAP,
	input wire [NPIN*2-1:0] PIN_MODE,
	input wire [NPIN-1:0] PIN_OD,
	input wire [NPIN-1:0] PIN_INV_D,
	input wire [NPIN-1:0] PIN_INV_OE,
	input wire [NPIN-1:0] PIN_DLY,
	input wire [NPIN-1:0] PIN_ROW_EN,
	input wire [NPIN*`SEL_W-1:0] PIN_DSEL,
	input wire [NPIN*`SEL_W-1:0] PIN_OSEL,
	// Dedicated global inputs and chip-wide output disable.
	input wire [`GLOBALS-1:0] DED_IN,
	input wire CHIP_OUTPUT_DISABLE_PIN,
	// Logic cell outputs and column channels arriving from other rows.
	input wire [NCOL*`CELLS-1:0] CELL_GLOBAL,
	input wire [NCOL*`CELLS-1:0] CELL_LOCAL,
	input wire [NCOL*COL_CH-1:0] COL_IN,
	// Pin cells.
	input wire [NPIN-1:0] PIN_IN,
	output wire [NPIN-1:0] PIN_OUT,
	output wire [NPIN-1:0] PIN_OEN,
	// Routing toward logic cells and other rows.
	output wire [NCOL*NLOCAL-1:0] CL_LOCAL,
	output wire [NCOL-1:0] CL_CLK,
	output wire [NCOL-1:0] CL_CLR,
	output wire [NCOL-1:0] CL_PRE,
	output wire [NCOL*COL_CH-1:0] COL_OUT,
	output wire [ROW_CH+ROW_CH/3-1:0] ROW_TRACK,
	output wire [`GLOBALS-1:0] GLOBAL_NET
);

	// Half-length channels are stored as two segments, one per half of the row.
	localparam HALF = ROW_CH / 3;
	localparam FULL = ROW_CH - HALF;
	localparam TRK = FULL + 2 * HALF;
	localparam NG = (TRK + `GROUP_SIZE - 1) / `GROUP_SIZE;
	localparam NB = 2 * `CELLS;
	localparam SRC = ROW_CH + `GLOBALS + NB;
	localparam EDGE = ROW_CH + NB;

	reg [2*NG-1:0] cfg_grp_sel;
	reg [NCOL*NLOCAL*`SEL_W-1:0] cfg_loc_sel;
	reg [NCOL*6-1:0] cfg_ctrl_sel;
	reg [NCOL*COL_CH*2-1:0] cfg_col_sel;
	reg [`GLOBALS-1:0] cfg_glb_src;
	reg [`GLOBALS*`SEL_W-1:0] cfg_glb_tap;
	reg [NPIN*2-1:0] cfg_pin_mode;
	reg [NPIN-1:0] cfg_pin_od;
	reg [NPIN-1:0] cfg_pin_inv_d;
	reg [NPIN-1:0] cfg_pin_inv_oe;
	reg [NPIN-1:0] cfg_pin_dly;
	reg [NPIN-1:0] cfg_pin_row_en;
	reg [NPIN*`SEL_W-1:0] cfg_pin_dsel;
	reg [NPIN*`SEL_W-1:0] cfg_pin_osel;
	reg [NPIN-1:0] pin_delayed;
	wire [NG-1:0] grp_drv;
	wire [TRK-1:0] track;
	wire [NCOL*ROW_CH-1:0] vis_all;
	wire [NCOL*NB-1:0] nb_all;
	wire [NCOL*SRC-1:0] src_all;
	wire [`GLOBALS-1:0] glob;
	wire [NPIN-1:0] pin_val;

	// Configuration is captured only on a load strobe and otherwise holds, so routing
	// never changes under running logic. Reset turns every row group driver off, sets column channels to pass-through and makes every pin an input.
	always @(posedge REF_CLK) begin
		if (!RESETN) begin
			cfg_grp_sel <= {2*NG{`CFG_RESET}};
			cfg_loc_sel <= {NCOL*NLOCAL*`SEL_W{`CFG_RESET}};
			cfg_ctrl_sel <= {NCOL*6{`CFG_RESET}};
			cfg_col_sel <= {NCOL*COL_CH*2{`CFG_RESET}};
			cfg_glb_src <= {`GLOBALS{`CFG_RESET}};
			cfg_glb_tap <= {`GLOBALS*`SEL_W{`CFG_RESET}};
			cfg_pin_mode <= {NPIN*2{`CFG_RESET}};
			cfg_pin_od <= {NPIN{`CFG_RESET}};
			cfg_pin_inv_d <= {NPIN{`CFG_RESET}};
			cfg_pin_inv_oe <= {NPIN{`CFG_RESET}};
			cfg_pin_dly <= {NPIN{`CFG_RESET}};
			cfg_pin_row_en <= {NPIN{`CFG_RESET}};
			cfg_pin_dsel <= {NPIN*`SEL_W{`CFG_RESET}};
			cfg_pin_osel <= {NPIN*`SEL_W{`CFG_RESET}};
		end else if (CFG_LOAD) begin
			cfg_grp_sel <= GRP_SEL;
			cfg_loc_sel <= LOC_SEL;
			cfg_ctrl_sel <= CTRL_SEL;
			cfg_col_sel <= COL_SEL;
			cfg_glb_src <= GLB_SRC;
			cfg_glb_tap <= GLB_TAP;
			cfg_pin_mode <= PIN_MODE;
			cfg_pin_od <= PIN_OD;
			cfg_pin_inv_d <= PIN_INV_D;
			cfg_pin_inv_oe <= PIN_INV_OE;
			cfg_pin_dly <= PIN_DLY;
			cfg_pin_row_en <= PIN_ROW_EN;
			cfg_pin_dsel <= PIN_DSEL;
			cfg_pin_osel <= PIN_OSEL;
		end
	end

	// The optional input delay is one reference clock stage on every pad.
	always @(posedge REF_CLK) begin
		if (!RESETN) begin
			pin_delayed <= {NPIN{1'h0}};
		end else begin
			pin_delayed <= PIN_IN;
		end
	end

	genvar g, t, c, l, j, p, q;

	// Row group drivers: one three-way selector per group of six channels.
	generate
		for (g = 0; g < NG; g = g + 1) begin : row_group
			localparam T0 = g * `GROUP_SIZE;
			localparam KIND = (T0 < FULL) ? 0 : ((T0 < FULL + HALF) ? 1 : 2);
			localparam GC = (KIND == 0) ? (g % NCOL) : ((KIND == 1) ? (g % (NCOL / 2)) : (NCOL / 2 + g % (NCOL / 2)));
			localparam CELL = GC * `CELLS + g % `CELLS;
			wire [1:0] s;
			wire cell_src;
			wire sel_out;
			assign s = cfg_grp_sel[2*g +: 2];
			// Even groups carry a cell's global output, odd groups its local channel.
			if (g % 2 == 0) begin : from_global
				assign cell_src = CELL_GLOBAL[CELL];
			end else begin : from_local
				assign cell_src = CELL_LOCAL[CELL];
			end
			assign sel_out = (s == `GSEL_CELL) ? cell_src :
				(s == `GSEL_COLA) ? COL_IN[GC*COL_CH + g % COL_CH] :
				(s == `GSEL_COLB) ? COL_IN[GC*COL_CH + (g + 1) % COL_CH] : 1'h0;
			// An input pin with row drive enabled takes over its group's six lines.
			if (g < NPIN) begin : pin_drive
				assign grp_drv[g] = cfg_pin_row_en[g] ? pin_val[g] : sel_out;
			end else begin : no_pin
				assign grp_drv[g] = sel_out;
			end
		end
		for (t = 0; t < TRK; t = t + 1) begin : row_track
			assign track[t] = grp_drv[t / `GROUP_SIZE];
		end
	endgenerate

	assign ROW_TRACK = track;

	// Global nets: a net taken over by an edge cluster no longer sees its dedicated pin.
	generate
		for (q = 0; q < `GLOBALS; q = q + 1) begin : global_net
			localparam EC = (q < 2) ? 0 : NCOL - 1;
			wire [`SEL_W-1:0] tap;
			wire edge_bit;
			assign tap = cfg_glb_tap[q*`SEL_W +: `SEL_W];
			// Taps reach only row and neighbour routing, never another global, so no loop forms.
			assign edge_bit = (tap < ROW_CH) ? vis_all[EC*ROW_CH + tap] :
				(tap < EDGE) ? nb_all[EC*NB + tap - ROW_CH] : 1'h0;
			assign glob[q] = cfg_glb_src[q] ? edge_bit : DED_IN[q];
		end
	endgenerate

	assign GLOBAL_NET = glob;

	// Clusters: row-to-local selectors over visible row channels, globals and neighbour cells.
	generate
		for (c = 0; c < NCOL; c = c + 1) begin : cluster
			localparam HOFF = (c < NCOL / 2) ? FULL : FULL + HALF;
			wire [`HALF_CELLS-1:0] from_left;
			wire [`HALF_CELLS-1:0] from_right;
			wire [5:0] cs;
			// Cells 1-5 drive rightward and 6-10 leftward into the adjacent clusters.
			if (c > 0) begin : has_left
				assign from_left = CELL_LOCAL[(c-1)*`CELLS +: `HALF_CELLS];
			end else begin : no_left
				assign from_left = {`HALF_CELLS{1'h0}};
			end
			if (c < NCOL - 1) begin : has_right
				assign from_right = CELL_LOCAL[(c+1)*`CELLS + `HALF_CELLS +: `HALF_CELLS];
			end else begin : no_right
				assign from_right = {`HALF_CELLS{1'h0}};
			end
			assign nb_all[c*NB +: NB] = {from_right, from_left, CELL_LOCAL[c*`CELLS +: `CELLS]};
			// A cluster sees all full channels and only its own half's segment.
			assign vis_all[c*ROW_CH +: ROW_CH] = {track[HOFF +: HALF], track[0 +: FULL]};
			// Column channels are absent from this vector on purpose.
			assign src_all[c*SRC +: SRC] = {nb_all[c*NB +: NB], glob, vis_all[c*ROW_CH +: ROW_CH]};
			for (l = 0; l < NLOCAL; l = l + 1) begin : local_sel
				wire [`SEL_W-1:0] idx;
				assign idx = cfg_loc_sel[(c*NLOCAL+l)*`SEL_W +: `SEL_W];
				assign CL_LOCAL[c*NLOCAL+l] = (idx < SRC) ? src_all[c*SRC + idx] : 1'h0;
			end
			// Each cluster picks its clock, clear and preset from any global net.
			assign cs = cfg_ctrl_sel[c*6 +: 6];
			assign CL_CLK[c] = glob[cs[1:0]];
			assign CL_CLR[c] = glob[cs[3:2]];
			assign CL_PRE[c] = glob[cs[5:4]];
		end
	endgenerate

	// Column channel drivers: pass-through, a cell global, a cell local line or a pin.
	generate
		for (c = 0; c < NCOL; c = c + 1) begin : col
			for (j = 0; j < COL_CH; j = j + 1) begin : chan
				localparam K = c * COL_CH + j;
				wire [1:0] s;
				assign s = cfg_col_sel[2*K +: 2];
				// Cell k owns channels k and k+10 from its global output, two more from its local.
				assign COL_OUT[K] = (s == `CSEL_GLOBAL) ? CELL_GLOBAL[c*`CELLS + j % `CELLS] :
					(s == `CSEL_LOCAL) ? CELL_LOCAL[c*`CELLS + (j + `HALF_CELLS) % `CELLS] :
					(s == `CSEL_PIN) ? pin_val[K % NPIN] : COL_IN[K];
			end
		end
	endgenerate

	// Pin cells: left-half pins use the leftmost cluster's routing, the rest the rightmost.
	generate
		for (p = 0; p < NPIN; p = p + 1) begin : pin
			localparam PC = (p < NPIN / 2) ? 0 : NCOL - 1;
			wire [1:0] mode;
			wire [`SEL_W-1:0] dsel;
			wire [`SEL_W-1:0] osel;
			wire in_use;
			wire out_use;
			wire d_raw;
			wire oe_raw;
			wire d_pol;
			wire oe_pol;
			wire drive;
			assign mode = cfg_pin_mode[2*p +: 2];
			assign dsel = cfg_pin_dsel[p*`SEL_W +: `SEL_W];
			assign osel = cfg_pin_osel[p*`SEL_W +: `SEL_W];
			assign in_use = (mode == `PMODE_INPUT) || (mode == `PMODE_BIDIR);
			assign out_use = (mode == `PMODE_OUTPUT) || (mode == `PMODE_BIDIR);
			// Data and enable both come from the adjacent local routing.
			assign d_raw = (dsel < SRC) ? src_all[PC*SRC + dsel] : 1'h0;
			assign oe_raw = (osel < SRC) ? src_all[PC*SRC + osel] : 1'h0;
			assign d_pol = d_raw ^ cfg_pin_inv_d[p];
			assign oe_pol = oe_raw ^ cfg_pin_inv_oe[p];
			// The chip disable wins over every per-pin enable, whatever the mode.
			assign drive = out_use & oe_pol & ~CHIP_OUTPUT_DISABLE_PIN;
			// Open drain: data forced low, so the pin can only pull low or float.
			assign PIN_OUT[p] = cfg_pin_od[p] ? 1'h0 : d_pol;
			assign PIN_OEN[p] = ~drive;
			// The delay adds one cycle of latency; turn it on only where hold time is at risk.
			assign pin_val[p] = in_use & (cfg_pin_dly[p] ? pin_delayed[p] : PIN_IN[p]);
		end
	endgenerate

endmodule // routing_fabric

`default_nettype wire

// [verification/routing_fabric_props.sv]
// Concurrent checks on the routing fabric ports.
`default_nettype none
`include "fabric_map.vh"
module routing_fabric_props #(
	parameter ROW_CH = 144,
	parameter COL_CH = 20,
	parameter NCOL = 22,
	parameter NPIN = 20
) (
	// Clock, reset and configuration.
	input wire logic REF_CLK,
	input wire logic RESETN,
	input wire logic CFG_LOAD,
	input wire logic [2*((ROW_CH+ROW_CH/3+5)/6)-1:0] GRP_SEL,
	input wire logic [NPIN-1:0] PIN_OD,
	input wire logic [NPIN-1:0] PIN_ROW_EN,
	// Sources.
	input wire logic [3:0] DED_IN,
	input wire logic CHIP_OUTPUT_DISABLE_PIN,
	input wire logic [NCOL*`CELLS-1:0] CELL_GLOBAL,
	input wire logic [NCOL*`CELLS-1:0] CELL_LOCAL,
	input wire logic [NCOL*COL_CH-1:0] COL_IN,
	input wire logic [NPIN-1:0] PIN_IN,
	// Routed results.
	input wire logic [NPIN-1:0] PIN_OUT,
	input wire logic [NPIN-1:0] PIN_OEN,
	input wire logic [NCOL-1:0] CL_CLK,
	input wire logic [NCOL*COL_CH-1:0] COL_OUT,
	input wire logic [ROW_CH+ROW_CH/3-1:0] ROW_TRACK,
	input wire logic [3:0] GLOBAL_NET
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [NPIN-1:0] pin_d;
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RESETN);
	// Pad history, so the delay stage does not look like a config change.
	always_ff @(posedge REF_CLK) pin_d <= PIN_IN;
	a_disable_floats: assert property (CHIP_OUTPUT_DISABLE_PIN |-> &PIN_OEN)
		else $error("pin driven while chip outputs disabled");
	a_reset_inputs: assert property (!$past(RESETN) |-> &PIN_OEN)
		else $error("pin driven after reset");
	a_reset_globals: assert property (!$past(RESETN) |-> GLOBAL_NET == DED_IN)
		else $error("global not from dedicated input after reset");
	a_reset_colpass: assert property (!$past(RESETN) |-> COL_OUT == COL_IN)
		else $error("column not passing after reset");
	a_reset_trackoff: assert property (!$past(RESETN) |-> ROW_TRACK == '0)
		else $error("row channel driven after reset");
	a_reset_clock: assert property (!$past(RESETN) |-> CL_CLK == {NCOL{GLOBAL_NET[0]}})
		else $error("cluster clock not on global zero");
	a_open_drain: assert property ($past(RESETN) && $past(CFG_LOAD) |-> (PIN_OUT & $past(PIN_OD)) == '0)
		else $error("open drain pin data high");
	a_group_drive: assert property ($past(RESETN) && $past(CFG_LOAD) && $past(GRP_SEL[1:0]) == `GSEL_CELL
		&& !$past(PIN_ROW_EN[0]) |-> ROW_TRACK[5:0] == {6{CELL_GLOBAL[0]}})
		else $error("group zero not following its cell");
	a_static_config: assert property ($past(RESETN) && !$past(CFG_LOAD) && $stable(CELL_GLOBAL)
		&& $stable(CELL_LOCAL) && $stable(COL_IN) && $stable(pin_d) && PIN_IN == pin_d
		|-> $stable(ROW_TRACK))
		else $error("row channels moved without a load");
endmodule // routing_fabric_props
bind routing_fabric routing_fabric_props #(.ROW_CH(ROW_CH), .COL_CH(COL_CH), .NCOL(NCOL), .NPIN(NPIN))
	routing_fabric_props_inst (.REF_CLK, .RESETN, .CFG_LOAD, .GRP_SEL, .PIN_OD, .PIN_ROW_EN, .DED_IN,
	.CHIP_OUTPUT_DISABLE_PIN, .CELL_GLOBAL, .CELL_LOCAL, .COL_IN, .PIN_IN, .PIN_OUT, .PIN_OEN, .CL_CLK,
	.COL_OUT, .ROW_TRACK, .GLOBAL_NET);
`default_nettype wire

// [verification/pin_board.sv]
// Board side of the user pins: pull-ups and optional external drivers.
`default_nettype none
module pin_board #(
	parameter N = 20
) (
	// Device side.
	input wire logic [N-1:0] drv_data,
	input wire logic [N-1:0] drv_oen,
	// Board drivers and resolved pad level.
	input wire logic [N-1:0] ext_en,
	input wire logic [N-1:0] ext_val,
	output logic [N-1:0] pad
);
	timeunit 1ns;
	timeprecision 1ns;
	// A released pin floats to the pull-up, so open drain reads high when off.
	assign pad = (~drv_oen & drv_data) | (drv_oen & ((ext_en & ext_val) | ~ext_en));
endmodule // pin_board
`default_nettype wire

// [verification/routing_fabric_bench.sv]
// Self-checking bench for the routing fabric and its pin cells.
`default_nettype none
`include "fabric_map.vh"
module routing_fabric_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rstn = 0, ld = 0, dis = 0;
	logic [63:0] grp = '0;
	logic [4223:0] loc = '0;
	logic [131:0] ctrl = '0;
	logic [879:0] csel = '0;
	logic [3:0] gsrc = '0, ded = 4'h5;
	logic [31:0] gtap = '0;
	logic [39:0] mode = '0;
	logic [19:0] od = '0, invd = '0, invoe = '0, dly = '0, rowen = '0, ext = '0, exten = '0;
	logic [159:0] dsel = '0, osel = '0;
	logic [219:0] cg = '0, cl = '0;
	logic [439:0] cin = '0;
	logic [439:0] cout;
	logic [19:0] pad, pout, poen;
	logic [3:0] gnet;
	logic [21:0] cclk, cclr, cpre;
	logic [527:0] clocal;
	logic [191:0] track;
	int error_cnt = 0, checks = 0, k;
	routing_fabric routing_fabric_inst (.REF_CLK(clk), .RESETN(rstn), .CFG_LOAD(ld), .GRP_SEL(grp),
		.LOC_SEL(loc), .CTRL_SEL(ctrl), .COL_SEL(csel), .GLB_SRC(gsrc), .GLB_TAP(gtap), .PIN_MODE(mode),
		.PIN_OD(od), .PIN_INV_D(invd), .PIN_INV_OE(invoe), .PIN_DLY(dly), .PIN_ROW_EN(rowen),
		.PIN_DSEL(dsel), .PIN_OSEL(osel), .DED_IN(ded), .CHIP_OUTPUT_DISABLE_PIN(dis), .CELL_GLOBAL(cg),
		.CELL_LOCAL(cl), .COL_IN(cin), .PIN_IN(pad), .PIN_OUT(pout), .PIN_OEN(poen), .CL_LOCAL(clocal),
		.CL_CLK(cclk), .CL_CLR(cclr), .CL_PRE(cpre), .COL_OUT(cout), .ROW_TRACK(track), .GLOBAL_NET(gnet));
	pin_board pin_board_inst (.drv_data(pout), .drv_oen(poen), .ext_en(exten), .ext_val(ext), .pad(pad));
	// Free-running 25 MHz clock; inputs move on its falling edge.
	initial begin
		forever #20 clk = ~clk;
	end
	task chk(input logic [191:0] got, input logic [191:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Fields are set first; the capture edge passes and we stand at the next falling edge.
	task load;
		ld = 1;
		@(negedge clk);
		ld = 0;
		#1;
	endtask
	task rst(input int n);
		rstn = 0;
		repeat (n) @(negedge clk);
		rstn = 1;
		#1;
	endtask
	task tally_and_finish;
		$display("checks=%0d error_cnt=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// A hung run is cut short well past the expected few microseconds.
	initial begin
		#20us;
		error_cnt++;
		tally_and_finish();
	end
	// Main sequence.
	initial begin
		cin[39:2] = 38'h3F_A5C3_96E1;
		rst(16);
		chk(poen, {20{1'b1}});
		chk(track, '0);
		chk(gnet, ded);
		chk(cout[191:0], cin[191:0]);
		// Each group source in turn: the chosen one high, the others low; off with all high.
		for (k = 0; k < 4; k++) begin
			grp[1:0] = k[1:0];
			load();
			{cin[1], cin[0], cg[0]} = k ? 3'h1 << (k - 1) : 3'h7;
			#1;
			chk(track[5:0], k ? 6'h3F : 6'h0);
		end
		grp[1:0] = `GSEL_OFF;
		#1;
		chk(track[5:0], 6'h3F);
		grp[1:0] = `GSEL_CELL;
		gsrc = 4'h1;
		load();
		cg[0] = 1;
		ded = 4'h0;
		#1;
		chk(gnet[0], 1'b1);
		chk(cclk, {22{1'b1}});
		cg[0] = 0;
		ded[0] = 1;
		#1;
		chk(gnet[0], 1'b0);
		// Pin zero: data from row channel zero, enable from dedicated input zero.
		gsrc = 4'h0;
		osel[7:0] = 8'h90;
		cg[0] = 1;
		for (k = 0; k < 4; k++) begin
			mode[1:0] = k[1:0];
			load();
			chk(poen[0], k == `PMODE_INPUT || k == `PMODE_UNUSED);
		end
		mode[1:0] = `PMODE_OUTPUT;
		for (k = 0; k < 8; k++) begin
			{invoe[0], invd[0], od[0]} = k[2:0];
			load();
			chk(poen[0], k[2]);
			chk(pout[0], !k[0] && !k[1]);
			chk(pad[0], k[2] || (!k[0] && !k[1]));
		end
		{invoe[0], invd[0], od[0]} = 3'h0;
		load();
		dis = 1;
		#1;
		chk(poen[0], 1'b1);
		chk(pad[0], 1'b1);
		dis = 0;
		// Pad back onto row channels, first direct, then through the delay stage.
		mode[1:0] = `PMODE_INPUT;
		rowen[0] = 1;
		grp[1:0] = `GSEL_OFF;
		exten[0] = 1;
		load();
		ext[0] = 1;
		#1;
		chk(track[5:0], 6'h3F);
		dly[0] = 1;
		ext[0] = 0;
		load();
		ext[0] = 1;
		#1;
		chk(track[5:0], 6'h0);
		@(negedge clk);
		#1;
		chk(track[5:0], 6'h3F);
		// Globals as local data and as per-cluster controls; a left neighbour's cell seen locally.
		ded = 4'h6;
		loc[7:0] = 8'h91;
		loc[199:192] = 8'h9E;
		ctrl[5:0] = 6'h27;
		cl[0] = 1;
		load();
		chk(clocal[0], 1'b1);
		chk(clocal[24], 1'b1);
		chk(cclk[0], 1'b0);
		chk(cclr[0], 1'b1);
		chk(cpre[0], 1'b1);
		rst(2);
		chk(poen, {20{1'b1}});
		tally_and_finish();
	end
endmodule // routing_fabric_bench
`default_nettype wire
